// ===== rtl/host_port_defs.svh
// Purpose: Constants of the parallel host port
// Assumes: Included by bare name
// Notes: Offsets are byte addresses on the host bus
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH

// ----------------------------------------
// Address map
// ----------------------------------------
`define HP_ADDR_W 8
`define HP_FIFO_ADDR 8'h00
`define HP_STAT_ADDR 8'h02
`define HP_REG_BASE 8'h10
`define HP_REG_COUNT 16

// ----------------------------------------
// Queue sizes, reset values and state codes
// ----------------------------------------
`define HP_QUEUE_DEPTH 64
`define HP_HALF_LEN 7'h20
`define HP_MIN_LEN 7'h02
`define HP_REG_RESET 8'h00
`define HP_ST_IDLE 5'h01
`define HP_ST_EXEC 5'h02
`define HP_ST_FETCH 5'h04
`define HP_ST_SECOND 5'h08
`define HP_ST_HOLD 5'h10

`endif

// ===== rtl/host_port_pkg.sv
// Purpose: Types shared by the host port files
// Assumes: host_port_defs.svh holds the numbers
// Notes: State codes are one-hot
`include "host_port_defs.svh"

package host_port_pkg;

  // ----------------------------------------
  // Access sequencer states
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = `HP_ST_IDLE,
    ST_EXEC = `HP_ST_EXEC,
    ST_FETCH = `HP_ST_FETCH,
    ST_SECOND = `HP_ST_SECOND,
    ST_HOLD = `HP_ST_HOLD
  } state_type;

  // Lane decode of one access
  typedef struct packed {
    logic word;
    logic even;
    logic odd;
    logic none;
  } lane_type;

  // Captured access
  typedef struct packed {
    logic read;
    logic word;
    logic odd;
    logic [`HP_ADDR_W-1:0] addr;
    logic [7:0] wdEven;
    logic [7:0] wdOdd;
  } access_type;

endpackage : host_port_pkg

// ===== rtl/queue_buffer.sv
// Purpose: Byte queue with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Read data come from a register one cycle after the pop
`timescale 1ns/1ps

module queue_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Filling side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Draining side
  input wire logic outReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic inReady_q;
  logic [WIDTH-1:0] outData_q;

  // ----------------------------------------
  // Handshakes
  // ----------------------------------------
  wire push = inValid & inReady_q;
  wire pop = outReady & outValid;
  assign outValid = (count_q != '0);
  assign count_d = count_q + CW'(push) - CW'(pop);
  assign inReady = inReady_q;
  assign outData = outData_q;
  assign count = count_q;

  // Pointers, count and the registered ready
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      inReady_q <= 1'b1;
      outData_q <= '0;
    end else begin
      wrPtr_q <= wrPtr_q + AW'(push);
      rdPtr_q <= rdPtr_q + AW'(pop);
      count_q <= count_d;
      inReady_q <= (count_d < CW'(DEPTH));
      if (pop) outData_q <= mem[rdPtr_q];
    end
  end

  // Storage
  always_ff @(posedge clk) begin
    if (push) mem[wrPtr_q] <= inData;
  end

endmodule : queue_buffer

// ===== rtl/host_bus_port.sv
// Purpose: Parallel host port with register bank and two byte queues
// Assumes: Host pins are synchronous to clk; clk runs during reset
// Notes: One access per falling read or write strobe
`timescale 1ns/1ps
`include "host_port_defs.svh"

module host_bus_port import host_port_pkg::*; #(
  parameter int REG_COUNT = `HP_REG_COUNT,
  parameter int DEPTH = `HP_QUEUE_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Straps
  input wire logic intfStyleSelect,
  input wire logic busWidthSelect,
  // Host bus
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic ale,
  input wire logic [`HP_ADDR_W-1:1] addrHigh,
  input wire logic addrBit0,
  input wire logic highLaneSelectN,
  input wire logic styleOneLaneSelectN,
  input wire logic [15:0] dataIn,
  output logic [15:0] dataOut,
  output logic [1:0] dataOe,
  // Pad control and configuration
  output logic pullupEnable,
  input wire logic [5:0] rxEffLen,
  // Receive highway side
  input wire logic rxHwValid,
  input wire logic [7:0] rxHwData,
  output logic rxHwReady,
  // Transmit highway side
  input wire logic txHwReady,
  output logic txHwValid,
  output logic [7:0] txHwData
);
  localparam int CW = $clog2(DEPTH+1);
  localparam int IW = $clog2(REG_COUNT);

  state_type state_q, state_d;
  access_type acc_q;
  lane_type lane;
  logic rdQ, wrQ, aleQ, aleSeen_q;
  logic aleArm_q;
  logic [`HP_ADDR_W-1:0] addrLatch_q;
  logic [7:0] rdEven_q, rdOdd_q;
  logic [15:0] dataOut_q;
  logic [1:0] dataOe_q;
  logic pullup_q, txHwValid_q;
  logic [7:0] regBank_q [REG_COUNT];
  logic [CW-1:0] rxCount, txCount;
  logic [7:0] rxByte;
  logic rxOutValid, txOutValid, txInReady;

  // ----------------------------------------
  // Bus style and lane decode
  // ----------------------------------------
  wire styleOne = intfStyleSelect;
  wire wide = busWidthSelect;
  wire muxMode = aleSeen_q & ~styleOne;
  wire [`HP_ADDR_W-1:0] busAddr = muxMode ? addrLatch_q : {addrHigh, addrBit0};
  wire selN = styleOne ? styleOneLaneSelectN : highLaneSelectN;
  wire bit0 = busAddr[0];
  assign lane.word = wide & ~selN & ~bit0;
  assign lane.odd = wide ? (~selN & bit0) : bit0;
  assign lane.even = wide ? (selN & ~bit0) : ~bit0;
  assign lane.none = wide & selN & bit0;

  // Even register sits high in wide style one, low otherwise
  wire [7:0] evenIn = (wide & styleOne) ? dataIn[15:8] : dataIn[7:0];
  wire [7:0] oddIn = (wide & ~styleOne) ? dataIn[15:8] : dataIn[7:0];

  // Strobe edges
  wire rdFall = rdQ & ~rdN;
  wire wrFall = wrQ & ~wrN;
  wire stIdle = (state_q == ST_IDLE);
  wire strobe = stIdle & ~csN & (rdFall | wrFall);
  wire start = strobe & ~lane.none;

  // Target of the captured access
  wire accFifo = (acc_q.addr[7:1] == `HP_FIFO_ADDR >> 1);
  wire accStat = (acc_q.addr[7:1] == `HP_STAT_ADDR >> 1);
  wire [7:0] regOff = acc_q.addr - `HP_REG_BASE;
  wire accReg = (acc_q.addr >= `HP_REG_BASE) && (regOff < 8'(REG_COUNT));
  wire [IW-1:0] idxEven = {regOff[IW-1:1], 1'b0};

  // ----------------------------------------
  // Receive window and queue strobes
  // ----------------------------------------
  wire [6:0] effLen = ({1'b0, rxEffLen} < `HP_MIN_LEN) ? `HP_MIN_LEN :
                      ({1'b0, rxEffLen} > `HP_HALF_LEN) ? `HP_HALF_LEN :
                      {1'b0, rxEffLen};
  wire [6:0] rxVis = (7'(rxCount) > effLen) ? effLen : 7'(rxCount);
  wire rxHave = (rxVis != 7'h00);
  wire stExec = (state_q == ST_EXEC);
  wire stFetch = (state_q == ST_FETCH);
  wire stSecond = (state_q == ST_SECOND);
  wire stHold = (state_q == ST_HOLD);
  wire rxPop = acc_q.read & accFifo & rxHave & (stExec | (stFetch & acc_q.word));
  wire txPush = ~acc_q.read & accFifo & (stExec | stSecond);
  wire [7:0] txByte = (stSecond | (acc_q.odd & ~acc_q.word)) ? acc_q.wdOdd : acc_q.wdEven;
  wire regWrite = stExec & ~acc_q.read & accReg;

  // Next state of the access sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (start) state_d = ST_EXEC;
      ST_EXEC: begin
        if (acc_q.read & accFifo & rxHave) state_d = ST_FETCH;
        else if (~acc_q.read & accFifo & acc_q.word) state_d = ST_SECOND;
        else state_d = ST_HOLD;
      end
      ST_FETCH: state_d = rxPop ? ST_SECOND : ST_HOLD;
      ST_SECOND: state_d = ST_HOLD;
      ST_HOLD: if (csN | (rdN & wrN)) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Read data and bus drive
  // ----------------------------------------
  wire [15:0] rdWord = ~wide ? {8'h00, acc_q.odd ? rdOdd_q : rdEven_q} :
                       styleOne ? {rdEven_q, rdOdd_q} : {rdOdd_q, rdEven_q};
  wire [1:0] laneOe = (~wide) ? 2'b01 : acc_q.word ? 2'b11 :
                      (acc_q.odd ^ styleOne) ? 2'b10 : 2'b01;
  wire drive = stHold & acc_q.read & ~rdN & ~csN;
  wire [7:0] statEven = {1'b0, rxVis};
  wire [7:0] statOdd = 8'(txCount);

  // Sequencer, strobe history and address latch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      rdQ <= 1'b1;
      wrQ <= 1'b1;
      aleQ <= 1'b0;
      aleSeen_q <= 1'b0;
      aleArm_q <= 1'b0;
      addrLatch_q <= '0;
      acc_q <= '0;
    end else begin
      state_q <= state_d;
      rdQ <= rdN;
      wrQ <= wrN;
      aleQ <= ale;
      aleArm_q <= 1'b1;
      // Compare only once aleQ holds a real sample: a high strap is no toggle
      if (aleArm_q & (ale != aleQ)) aleSeen_q <= 1'b1;
      if (ale) addrLatch_q <= dataIn[`HP_ADDR_W-1:0];
      if (start) acc_q <= '{rdFall, lane.word, lane.odd, busAddr, evenIn, oddIn};
    end
  end

  // Read byte holders
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdEven_q <= 8'h00;
      rdOdd_q <= 8'h00;
    end else if (stExec) begin
      rdEven_q <= accReg ? regBank_q[idxEven] : accStat ? statEven : 8'h00;
      rdOdd_q <= accReg ? regBank_q[idxEven | IW'(1)] : accStat ? statOdd : 8'h00;
    end else if (stFetch & (acc_q.word | ~acc_q.odd)) begin
      rdEven_q <= rxByte;
    end else if (stFetch | (stSecond & acc_q.read)) begin
      rdOdd_q <= rxByte;
    end
  end

  // Registered pins; nothing drives during reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataOut_q <= 16'h0000;
      dataOe_q <= 2'b00;
      pullup_q <= 1'b1;
      txHwValid_q <= 1'b0;
    end else begin
      dataOut_q <= rdWord;
      dataOe_q <= drive ? laneOe : 2'b00;
      txHwValid_q <= txHwReady & txOutValid;
    end
  end

  assign dataOut = dataOut_q;
  assign dataOe = dataOe_q;
  assign pullupEnable = pullup_q;
  assign txHwValid = txHwValid_q;

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  genvar gi;
  for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
    wire hitEven = (idxEven == IW'(gi)) & (acc_q.word | ~acc_q.odd);
    wire hitOdd = ((idxEven | IW'(1)) == IW'(gi)) & (acc_q.word | acc_q.odd);
    // Even and odd bytes land on registers n and n+1
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) regBank_q[gi] <= `HP_REG_RESET;
      else if (regWrite & hitEven) regBank_q[gi] <= acc_q.wdEven;
      else if (regWrite & hitOdd) regBank_q[gi] <= acc_q.wdOdd;
    end
  end

  // ----------------------------------------
  // Queues, 64 bytes per direction
  // ----------------------------------------
  queue_buffer #(.WIDTH(8), .DEPTH(DEPTH)) rxQueue (
    .clk(clk), .sys_rst(sys_rst),
    .inValid(rxHwValid), .inData(rxHwData), .inReady(rxHwReady),
    .outReady(rxPop), .outValid(rxOutValid), .outData(rxByte), .count(rxCount)
  );

  queue_buffer #(.WIDTH(8), .DEPTH(DEPTH)) txQueue (
    .clk(clk), .sys_rst(sys_rst),
    .inValid(txPush), .inData(txByte), .inReady(txInReady),
    .outReady(txHwReady), .outValid(txOutValid), .outData(txHwData), .count(txCount)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_none_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    (strobe & lane.none) |=> (state_q == ST_IDLE) ##1 (dataOe_q == 2'b00))
    else $error("no-transfer access was acted on");
  chk_reset_float: assert property (@(posedge clk) sys_rst |-> dataOe_q == 2'b00)
    else $error("data bus driven in reset");
  chk_reset_pullup: assert property (@(posedge clk) sys_rst |-> pullupEnable)
    else $error("pullups off in reset");
  chk_zero_odd_lane: assert property (@(posedge clk) disable iff (sys_rst)
    (drive & wide & ~styleOne & acc_q.odd & ~acc_q.word) |=> dataOe_q == 2'b10)
    else $error("style zero odd byte on wrong lane");
  chk_one_odd_lane: assert property (@(posedge clk) disable iff (sys_rst)
    (drive & wide & styleOne & acc_q.odd & ~acc_q.word) |=> dataOe_q == 2'b01)
    else $error("style one odd byte on wrong lane");
  chk_word_layout: assert property (@(posedge clk) disable iff (sys_rst)
    (drive & wide & acc_q.word) |=> dataOut_q[15:8] ==
      (styleOne ? $past(rdEven_q) : $past(rdOdd_q)))
    else $error("word bytes placed wrongly");
  chk_narrow_word: assert property (@(posedge clk) disable iff (sys_rst)
    (start & ~wide) |=> !acc_q.word)
    else $error("word access in narrow mode");
  chk_rx_window: assert property (@(posedge clk) disable iff (sys_rst)
    (rxVis <= effLen) && (rxVis <= `HP_HALF_LEN) && (effLen >= `HP_MIN_LEN))
    else $error("receive window out of range");
  chk_tx_word_pair: assert property (@(posedge clk) disable iff (sys_rst)
    (stExec & ~acc_q.read & accFifo & acc_q.word) |-> txPush ##1 (txPush & stSecond))
    else $error("transmit word not pushed as two bytes");
  chk_mux_style: assert property (@(posedge clk) disable iff (sys_rst)
    styleOne |-> !muxMode)
    else $error("multiplexed bus in style one");

endmodule : host_bus_port

// ===== test/host_cpu_model.sv
// Purpose: Processor model driving the host bus of the port
// Assumes: Pins change just after a rising clk edge
// Notes: Released data lines show the inverse of the last value
`timescale 1ns/1ps
`include "host_port_defs.svh"

module host_cpu_model (
  // Clock
  input wire logic clk,
  // Bus toward the port
  output logic csN,
  output logic rdN,
  output logic wrN,
  output logic ale,
  output logic [`HP_ADDR_W-1:1] addrHigh,
  output logic addrBit0,
  output logic highLaneSelectN,
  output logic styleOneLaneSelectN,
  output logic [15:0] dataIn,
  // Answer from the port
  input wire logic [15:0] dataOut,
  input wire logic [1:0] dataOe
);
  // Idle bus, strobes high through reset
  initial begin
    csN = 1'h1;
    rdN = 1'h1;
    wrN = 1'h1;
    ale = 1'h0;
    addrHigh = 7'h00;
    addrBit0 = 1'h0;
    highLaneSelectN = 1'h1;
    styleOneLaneSelectN = 1'h1;
    dataIn = 16'h0000;
  end

  // Ties ale to a static level, as a board strap would
  task automatic tieAle(input logic v);
    ale <= v;
  endtask : tieAle

  // One read or write; mux adds an address phase on ale
  task automatic access(input logic rd, input logic st, input logic mux, input logic ls,
    input logic [7:0] addr, input logic [15:0] wd, output logic [15:0] rdat,
    output logic [1:0] oe);
    int n;
    rdat = 16'h0000;
    oe = 2'h0;
    @(posedge clk);
    if (mux) begin
      ale <= 1'h1; // Toggling ale selects the multiplexed bus in style zero
      dataIn <= {8'h00, addr};
      @(posedge clk);
      ale <= 1'h0;
    end
    addrHigh <= mux ? ~addr[7:1] : addr[7:1];
    addrBit0 <= addr[0];
    highLaneSelectN <= st ? ~ls : ls; // Unused select shows the inverse
    styleOneLaneSelectN <= st ? ls : ~ls;
    dataIn <= rd ? ~dataIn : wd;
    csN <= 1'h0;
    rdN <= ~rd;
    wrN <= rd;
    for (n = 0; n < (rd ? 8 : 2); n++) begin
      @(posedge clk);
      if (oe === 2'h0 && dataOe !== 2'h0) begin
        rdat = dataOut;
        oe = dataOe;
      end
    end
    csN <= 1'h1;
    rdN <= 1'h1;
    wrN <= 1'h1;
    dataIn <= ~dataIn;
    repeat (4) @(posedge clk);
  endtask : access
endmodule : host_cpu_model

// ===== test/host_bus_port_tb.sv
// Purpose: Self-checking bench of the host bus port
// Assumes: Straps change only under reset
// Notes: Runs style zero, style one, narrow, then multiplexed
`timescale 1ns/1ps
`include "host_port_defs.svh"

module host_bus_port_tb;
  logic clk, sys_rst, intfStyleSelect, busWidthSelect, csN, rdN, wrN, ale;
  logic addrBit0, highLaneSelectN, styleOneLaneSelectN, pullupEnable;
  logic rxHwValid, rxHwReady, txHwReady, txHwValid, st, w, mux;
  logic [`HP_ADDR_W-1:1] addrHigh;
  logic [15:0] dataIn, dataOut;
  logic [1:0] dataOe;
  logic [5:0] rxEffLen;
  logic [7:0] rxHwData, txHwData;
  logic [7:0] txExp [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  int error_cnt = 0;
  int compares = 0;

  host_bus_port host_bus_port_i (.clk(clk), .sys_rst(sys_rst),
    .intfStyleSelect(intfStyleSelect), .busWidthSelect(busWidthSelect), .csN(csN),
    .rdN(rdN), .wrN(wrN), .ale(ale), .addrHigh(addrHigh), .addrBit0(addrBit0),
    .highLaneSelectN(highLaneSelectN), .styleOneLaneSelectN(styleOneLaneSelectN),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .pullupEnable(pullupEnable),
    .rxEffLen(rxEffLen), .rxHwValid(rxHwValid), .rxHwData(rxHwData),
    .rxHwReady(rxHwReady), .txHwReady(txHwReady), .txHwValid(txHwValid),
    .txHwData(txHwData));
  host_cpu_model host_cpu_model_i (.clk(clk), .csN(csN), .rdN(rdN), .wrN(wrN),
    .ale(ale), .addrHigh(addrHigh), .addrBit0(addrBit0),
    .highLaneSelectN(highLaneSelectN), .styleOneLaneSelectN(styleOneLaneSelectN),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));

  // ----------------------------------------
  // Checking and verdict
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Expected lane enables of one access
  function automatic logic [1:0] lanes(input logic lsb, input logic ls);
    if (!w) return 2'h1;
    if (ls && lsb) return 2'h0;
    if (!ls && !lsb) return 2'h3;
    return (ls ^ st) ? 2'h1 : 2'h2;
  endfunction : lanes

  // Even and odd bytes placed on the lanes of the current style
  function automatic logic [15:0] place(input logic lsb, input logic ls, input logic [7:0] ev,
    input logic [7:0] od);
    logic [15:0] full;
    logic [1:0] m;
    m = lanes(lsb, ls);
    if (!w) full = {8'h00, lsb ? od : ev};
    else if (st) full = {ev, od};
    else full = {od, ev};
    return full & {{8{m[1]}}, {8{m[0]}}};
  endfunction : place

  // ----------------------------------------
  // Bus and highway tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic ls, input logic [7:0] ev, input logic [7:0] od);
    logic [15:0] d;
    logic [1:0] oe;
    d = (lanes(a[0], ls) == 2'h0) ? 16'hFFFF : place(a[0], ls, ev, od);
    host_cpu_model_i.access(1'h0, st, mux, ls, a, d, d, oe);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic ls, input logic [7:0] ev,
    input logic [7:0] od);
    logic [15:0] d;
    logic [1:0] oe;
    host_cpu_model_i.access(1'h1, st, mux, ls, a, 16'h0000, d, oe);
    check($sformatf("lanes %h", a), {14'h0000, oe}, {14'h0000, lanes(a[0], ls)});
    check($sformatf("data %h", a), d & {{8{oe[1]}}, {8{oe[0]}}}, place(a[0], ls, ev, od));
  endtask : rdChk

  task automatic doReset(input logic s, input logic wd);
    st = s;
    w = wd;
    sys_rst <= 1'h1;
    intfStyleSelect <= s;
    busWidthSelect <= wd; // Strap fixed while running
    rxEffLen <= 6'h20;
    repeat (10) @(posedge clk);
    check("pullup", {15'h0000, pullupEnable}, 16'h0001);
    check("oe in reset", {14'h0000, dataOe}, 16'h0000);
    sys_rst <= 1'h0;
    @(posedge clk);
  endtask : doReset

  task automatic pushRx(input logic [7:0] v);
    int n;
    rxHwValid <= 1'h1;
    rxHwData <= v;
    for (n = 0; n < 8; n++) begin
      @(posedge clk);
      if (rxHwReady === 1'h1) break;
    end
  endtask : pushRx

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic queueTest();
    int i, n;
    logic [7:0] k;
    logic ls, lsb;
    for (i = 0; i < 64; i++) pushRx(i[7:0]);
    rxHwValid <= 1'h0;
    repeat (2) @(posedge clk);
    check("rx full", {15'h0000, rxHwReady}, 16'h0000);
    rdChk(`HP_STAT_ADDR, 1'h0, 8'h20, 8'h00);
    rxEffLen <= 6'h02;
    repeat (2) @(posedge clk);
    rdChk(`HP_STAT_ADDR, 1'h0, 8'h02, 8'h00);
    rxEffLen <= 6'h00;
    repeat (2) @(posedge clk);
    rdChk(`HP_STAT_ADDR, 1'h0, 8'h02, 8'h00);
    rxEffLen <= 6'h3F;
    repeat (2) @(posedge clk);
    rdChk(`HP_STAT_ADDR, 1'h0, 8'h20, 8'h00);
    rxEffLen <= 6'h20;
    k = 8'h00;
    for (i = 0; i < 4; i++) begin
      ls = (i == 1);
      lsb = (i == 2);
      rdChk(`HP_FIFO_ADDR | lsb, ls, k, (w && !ls && !lsb) ? k + 8'h01 : k);
      k = k + ((w && !ls && !lsb) ? 8'h02 : 8'h01);
    end
    check("rx room", {15'h0000, rxHwReady}, 16'h0001);
    wr(`HP_FIFO_ADDR, 1'h0, 8'h11, 8'h22); // Tx stalled by highway meanwhile
    wr(`HP_FIFO_ADDR | 8'h01, 1'h0, 8'h33, 8'h33);
    wr(`HP_FIFO_ADDR, 1'h1, 8'h44, 8'h44);
    rdChk(`HP_STAT_ADDR, 1'h0, 8'h20, w ? 8'h04 : 8'h03);
    txHwReady <= 1'h1;
    n = 0;
    for (i = 0; i < 12; i++) begin
      @(posedge clk);
      if (txHwValid === 1'h1 && n < 4) begin
        check("tx byte", {8'h00, txHwData}, {8'h00, txExp[w ? n : n + (n > 0)]});
        n++;
      end
    end
    txHwReady <= 1'h0;
    check("tx count", n[15:0], w ? 16'h0004 : 16'h0003);
  endtask : queueTest

  task automatic regTest();
    wr(`HP_REG_BASE | 8'h02, 1'h1, 8'hA1, 8'hA1);
    wr(`HP_REG_BASE | 8'h03, 1'h0, 8'hB2, 8'hB2);
    if (w) wr(`HP_REG_BASE | 8'h03, 1'h1, 8'hFF, 8'hFF);
    rdChk(`HP_REG_BASE | 8'h02, 1'h0, 8'hA1, 8'hB2);
    rdChk(8'h40, 1'h0, 8'h00, 8'h00);
    if (w) begin
      wr(`HP_REG_BASE | 8'h04, 1'h0, 8'h5A, 8'hA5);
      rdChk(`HP_REG_BASE | 8'h05, 1'h0, 8'hA5, 8'hA5);
      rdChk(`HP_REG_BASE | 8'h04, 1'h1, 8'h5A, 8'h5A);
      rdChk(`HP_REG_BASE | 8'h05, 1'h1, 8'h00, 8'h00);
    end
  endtask : regTest

  // Clock of 8 ns
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  // Main sequence over three strap settings, then multiplexed
  initial begin
    sys_rst = 1'h0;
    intfStyleSelect = 1'h0;
    busWidthSelect = 1'h1;
    rxEffLen = 6'h20;
    rxHwValid = 1'h0;
    rxHwData = 8'h00;
    txHwReady = 1'h0;
    mux = 1'h0;
    for (int c = 0; c < 3; c++) begin
      doReset(c == 1, c != 2);
      regTest();
      queueTest();
    end
    // Ale strapped high through reset must leave the bus demultiplexed
    host_cpu_model_i.tieAle(1'h1);
    doReset(1'h0, 1'h1);
    wr(`HP_REG_BASE | 8'h08, 1'h0, 8'hC3, 8'h3C);
    rdChk(`HP_REG_BASE | 8'h08, 1'h0, 8'hC3, 8'h3C);
    host_cpu_model_i.tieAle(1'h0);
    doReset(1'h0, 1'h1);
    mux = 1'h1;
    wr(`HP_REG_BASE | 8'h06, 1'h0, 8'h6B, 8'hB6);
    rdChk(`HP_REG_BASE | 8'h06, 1'h0, 8'h6B, 8'hB6);
    final_report();
  end
endmodule : host_bus_port_tb
